//--- rtl/thal_consts.svh
`ifndef THAL_CONSTS_SVH
`define THAL_CONSTS_SVH
// ==========================================
// Register indices (byte address = 4 * index)
`define THAL_IDX_SEC     12'h000
`define THAL_IDX_MIN     12'h001
`define THAL_IDX_HOUR    12'h002
`define THAL_IDX_DAY     12'h003
`define THAL_IDX_ASEC    12'h007
`define THAL_IDX_AMIN    12'h008
`define THAL_IDX_AHOUR   12'h009
`define THAL_IDX_ADAY    12'h00A
`define THAL_IDX_THR_LO  12'h00B
`define THAL_IDX_THR_HI  12'h00C
`define THAL_IDX_RATE    12'h00D
`define THAL_IDX_CTRL    12'h00E
`define THAL_IDX_STAT    12'h014
`define THAL_IDX_CNT0    12'h01A
`define THAL_IDX_CNT1    12'h01B
`define THAL_IDX_CNT2    12'h01C
`define THAL_IDX_LOG_LO  12'h220
`define THAL_IDX_LOG_TOP 12'h27F
`define THAL_IDX_HIST    12'h800
`define THAL_IDX_HTOP    12'h87F
// ==========================================
// Field positions
`define THAL_CTRL_SE     4
`define THAL_CTRL_UNDER_TEMP_IRQ_EN   2
`define THAL_CTRL_OVER_TEMP_IRQ_EN   1
`define THAL_CTRL_AIE    0
`define THAL_STAT_MIP    5
`define THAL_STAT_TLF    2
`define THAL_STAT_THF    1
`define THAL_STAT_TIME_MATCH_FLAG   0
`define THAL_HOUR_12H    6
`define THAL_HOUR_PM     5
`define THAL_ALM_MASK    7
// ==========================================
// Fixed-zero masks and limits
`define THAL_MASK_TIME   8'h7F
`define THAL_MASK_DAY    8'h07
`define THAL_MASK_ADAY   8'h87
`define THAL_BIN_NONE    6'h3F
`define THAL_ENTRIES     4'hC
`define THAL_DUR_MAX     8'hFF
`define THAL_BIN_MAX     16'hFFFF
// ==========================================
// Timing
`define THAL_CLK_MHZ     20
`define THAL_PULSE_US    62500
`define THAL_PERIOD_US   500000
`define THAL_HOLD_US     500000
`endif

//--- rtl/thal_logger.sv
`include "thal_consts.svh"
// Function
// - Keep 63 sixteen-bit bins, low byte first.
// - Bin is temperature code without two LSBs.
// - Unused 64th bin reads zero, never updated.
// - Bin counters saturate at 65535.
// - Out of band sample sets high/low flag.
// - Temperature alarms interrupt only when enabled.
// - New violation stores three-byte sample count.
// - Duration byte counts consecutive violating samples.
// - Duration at 255 opens next entry.
// - Return to band freezes; new crossing reopens.
// - Twelve four-byte entries per threshold region.
// - Four 62.5 ms low pulses, half-second spacing.
// - Mission start pulses both LEDs together.
// - Status request pulses in or out LED.
// - Before first sample, alternate starting out-band.
// - Status via command, or half-second button hold during mission.
// - BCD registers keep fixed-zero bits zero.
// - Hours bit 6 selects 12h, bit 5 PM.
// - Alarm fields compared, bit 7 masks field.
// - Mask set picks weekly to per-second rate.
// - Time or control write ends mission.
// - Temperature code unsigned, half-degree steps.
// - Time match sets flag, gated interrupt.
// - Flags stay set until written zero.
// - Sampling continues when datalog is full.
module thal_logger #(
    parameter logic [23:0] PULSE_CYC  =
        24'(`THAL_PULSE_US * `THAL_CLK_MHZ),
    parameter logic [23:0] PERIOD_CYC =
        24'(`THAL_PERIOD_US * `THAL_CLK_MHZ),
    parameter logic [23:0] HOLD_CYC   =
        24'(`THAL_HOLD_US * `THAL_CLK_MHZ)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Timebase and converter
    input  wire logic        sec_tick,
    input  wire logic        sample_valid,
    input  wire logic [7:0]  temp_code,
    input  wire logic        spec_test_req,
    // Pins
    input  wire logic        start_button_n,
    output logic             in_band_led_n,
    output logic             out_band_led_n,
    output logic             irq_n,
    output logic             hour_pm
);
    thal_pkg::thal_state_t s;
    thal_pkg::thal_state_t n;
    logic [7:0]  wb;
    logic [7:0]  rd;
    logic [11:0] ri;
    logic [11:0] off;
    logic        wr;
    logic        go;
    logic        oob;
    logic        tmatch;
    logic        start;
    logic        status_req;
    logic [23:0] cnt_new;
    logic [5:0]  bin;
    logic [4:0]  ent;

    // ==========================================
    // Next-state logic
    always_comb begin
        n          = s;
        wb         = hwdata[7:0];
        wr         = s.ap_valid && s.ap_wr;
        start      = 1'b0;
        status_req = spec_test_req;
        rd         = 8'h00;
        ri         = haddr[13:2];
        off        = 12'h000;
        oob        = 1'b0;
        tmatch     = 1'b1;
        ent        = 5'h00;
        bin        = temp_code[7:2];
        go         = sample_valid && s.logging_active;
        cnt_new    = s.cnt + 24'h000001;

        // Register writes, data phase
        if (wr) begin
            case (s.ap_idx)
                `THAL_IDX_SEC:   n.tod[0] = wb & `THAL_MASK_TIME;
                `THAL_IDX_MIN:   n.tod[1] = wb & `THAL_MASK_TIME;
                `THAL_IDX_HOUR:  n.tod[2] = wb & `THAL_MASK_TIME;
                `THAL_IDX_DAY:   n.tod[3] = wb & `THAL_MASK_DAY;
                `THAL_IDX_ASEC:  n.alm[0] = wb;
                `THAL_IDX_AMIN:  n.alm[1] = wb;
                `THAL_IDX_AHOUR: n.alm[2] = wb;
                `THAL_IDX_ADAY:  n.alm[3] = wb & `THAL_MASK_ADAY;
                `THAL_IDX_THR_LO: n.thr_lo = wb;
                `THAL_IDX_THR_HI: n.thr_hi = wb;
                `THAL_IDX_CTRL:  n.ctrl = wb;
                `THAL_IDX_RATE: begin
                    n.rate = wb;
                    if (wb != 8'h00 && !s.ctrl[`THAL_CTRL_SE]) begin
                        start = !s.logging_active;
                    end
                end
                `THAL_IDX_STAT: begin
                    // Written one keeps a flag, zero clears it
                    n.logging_active  = s.logging_active  && wb[`THAL_STAT_MIP];
                    n.under_temp_flag  = s.under_temp_flag  && wb[`THAL_STAT_TLF];
                    n.over_temp_flag  = s.over_temp_flag  && wb[`THAL_STAT_THF];
                    n.time_match_flag = s.time_match_flag && wb[`THAL_STAT_TIME_MATCH_FLAG];
                end
                default: begin
                end
            endcase
            if (s.ap_idx <= `THAL_IDX_CTRL && s.ap_idx != `THAL_IDX_RATE) begin
                n.logging_active = 1'b0;
            end
        end

        // Histogram update
        if (go) begin
            n.cnt        = cnt_new;
            n.first_seen = 1'b1;
            if (bin != `THAL_BIN_NONE &&
                s.hist[bin] != `THAL_BIN_MAX) begin
                n.hist[bin] = s.hist[bin] + 16'h0001;
            end
        end

        // Alarm logging, index 0 low, 1 high
        for (int t = 0; t < 2; t++) begin
            oob = (t == 1) ? (temp_code >= s.thr_hi)
                           : (temp_code <= s.thr_lo);
            if (go && oob) begin
                n.viol_seen = 1'b1;
                if (t == 1) begin
                    n.over_temp_flag = 1'b1;
                end else begin
                    n.under_temp_flag = 1'b1;
                end
                if (!s.band[t].active ||
                    s.band[t].dur == `THAL_DUR_MAX) begin
                    if (s.band[t].idx < `THAL_ENTRIES) begin
                        ent = 5'(t * 12) + {1'b0, s.band[t].idx};
                        n.log[ent] = {8'h01, cnt_new};
                        n.band[t].idx    = s.band[t].idx + 4'h1;
                        n.band[t].dur    = 8'h01;
                        n.band[t].active = 1'b1;
                    end else begin
                        n.band[t].active = 1'b0;
                    end
                end else begin
                    ent = 5'(t * 12) + {1'b0, s.band[t].idx} - 5'h01;
                    n.band[t].dur = s.band[t].dur + 8'h01;
                    n.log[ent][31:24] = s.band[t].dur + 8'h01;
                end
            end else if (go) begin
                n.band[t].active = 1'b0;
            end
        end

        // Time-of-day alarm
        for (int i = 0; i < 4; i++) begin
            if (!s.alm[i][`THAL_ALM_MASK] &&
                s.alm[i][6:0] != s.tod[i][6:0]) begin
                tmatch = 1'b0;
            end
        end
        if (sec_tick && tmatch) begin
            n.time_match_flag = 1'b1;
        end
        n.hour_pm = n.tod[2][`THAL_HOUR_12H] &&
                    n.tod[2][`THAL_HOUR_PM];

        // Start button, synchronised then held
        n.btn_s1 = start_button_n;
        n.btn_s2 = s.btn_s1;
        if (!s.btn_s2) begin
            if (s.btn_cyc != HOLD_CYC - 24'h000001) begin
                n.btn_cyc = s.btn_cyc + 24'h000001;
            end else if (!s.btn_done) begin
                n.btn_done = 1'b1;
                if (s.logging_active) begin
                    status_req = 1'b1;
                end else if (s.ctrl[`THAL_CTRL_SE] && s.rate != 8'h00) begin
                    start = 1'b1;
                end
            end
        end else begin
            n.btn_cyc  = 24'h000000;
            n.btn_done = 1'b0;
        end

        // Mission start
        if (start) begin
            n.logging_active        = 1'b1;
            n.viol_seen  = 1'b0;
            n.first_seen = 1'b0;
            n.band[0].active = 1'b0;
            n.band[1].active = 1'b0;
        end

        // LED pulse sequencer
        if (s.led_busy) begin
            if (s.led_cyc == PERIOD_CYC - 24'h000001) begin
                n.led_cyc = 24'h000000;
                n.led_num = s.led_num + 2'h1;
                n.led_busy = s.led_num != 2'h3;
            end else begin
                n.led_cyc = s.led_cyc + 24'h000001;
            end
        end else if (start) begin
            n.led_busy = 1'b1;
            n.led_mode = thal_pkg::THAL_LED_BOTH;
            n.led_num  = 2'h0;
            n.led_cyc  = 24'h000000;
        end else if (status_req) begin
            n.led_busy = 1'b1;
            n.led_num  = 2'h0;
            n.led_cyc  = 24'h000000;
            if (s.logging_active && !s.first_seen) begin
                n.led_mode = thal_pkg::THAL_LED_ALT;
            end else if (s.viol_seen) begin
                n.led_mode = thal_pkg::THAL_LED_OUT;
            end else begin
                n.led_mode = thal_pkg::THAL_LED_IN;
            end
        end
        n.led_in_n  = 1'b1;
        n.led_out_n = 1'b1;
        if (s.led_busy && s.led_cyc < PULSE_CYC) begin
            case (s.led_mode)
                thal_pkg::THAL_LED_BOTH: begin
                    n.led_in_n  = 1'b0;
                    n.led_out_n = 1'b0;
                end
                thal_pkg::THAL_LED_IN:  n.led_in_n  = 1'b0;
                thal_pkg::THAL_LED_OUT: n.led_out_n = 1'b0;
                thal_pkg::THAL_LED_ALT: begin
                    n.led_out_n = s.led_num[0];
                    n.led_in_n  = !s.led_num[0];
                end
                default: begin
                end
            endcase
        end

        // Interrupt from enabled flags
        n.irq_n = !((n.over_temp_flag && n.ctrl[`THAL_CTRL_OVER_TEMP_IRQ_EN]) ||
                    (n.under_temp_flag && n.ctrl[`THAL_CTRL_UNDER_TEMP_IRQ_EN]) ||
                    (n.time_match_flag && n.ctrl[`THAL_CTRL_AIE]));

        // Bus address phase and read mux
        n.ap_valid = hsel && hready && htrans[1];
        n.ap_wr    = hwrite;
        n.ap_idx   = ri;
        case (ri)
            `THAL_IDX_SEC:    rd = s.tod[0];
            `THAL_IDX_MIN:    rd = s.tod[1];
            `THAL_IDX_HOUR:   rd = s.tod[2];
            `THAL_IDX_DAY:    rd = s.tod[3];
            `THAL_IDX_ASEC:   rd = s.alm[0];
            `THAL_IDX_AMIN:   rd = s.alm[1];
            `THAL_IDX_AHOUR:  rd = s.alm[2];
            `THAL_IDX_ADAY:   rd = s.alm[3];
            `THAL_IDX_THR_LO: rd = s.thr_lo;
            `THAL_IDX_THR_HI: rd = s.thr_hi;
            `THAL_IDX_RATE:   rd = s.rate;
            `THAL_IDX_CTRL:   rd = s.ctrl;
            `THAL_IDX_STAT:   rd = {2'h0, s.logging_active, 2'h0, s.under_temp_flag, s.over_temp_flag, s.time_match_flag};
            `THAL_IDX_CNT0:   rd = s.cnt[7:0];
            `THAL_IDX_CNT1:   rd = s.cnt[15:8];
            `THAL_IDX_CNT2:   rd = s.cnt[23:16];
            default: begin
                if (ri >= `THAL_IDX_HIST && ri <= `THAL_IDX_HTOP) begin
                    off = ri - `THAL_IDX_HIST;
                    if (off[6:1] != `THAL_BIN_NONE) begin
                        rd = off[0] ? s.hist[off[6:1]][15:8]
                                    : s.hist[off[6:1]][7:0];
                    end
                end else if (ri >= `THAL_IDX_LOG_LO &&
                             ri <= `THAL_IDX_LOG_TOP) begin
                    off = ri - `THAL_IDX_LOG_LO;
                    rd  = s.log[off[6:2]][8 * off[1:0] +: 8];
                end
            end
        endcase
        n.hrdata = (n.ap_valid && !hwrite) ? {24'h000000, rd} : 32'h00000000;
    end

    // ==========================================
    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s           <= '0;
            s.btn_s1    <= 1'b1;
            s.btn_s2    <= 1'b1;
            s.led_in_n  <= 1'b1;
            s.led_out_n <= 1'b1;
            s.irq_n     <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hrdata         = s.hrdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign in_band_led_n  = s.led_in_n;
    assign out_band_led_n = s.led_out_n;
    assign irq_n          = s.irq_n;
    assign hour_pm        = s.hour_pm;

    // ==========================================
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    hist_sat_a: assert property (
        (go && bin != `THAL_BIN_NONE && s.hist[bin] == `THAL_BIN_MAX)
        |=> s.hist[$past(bin)] == `THAL_BIN_MAX)
        else $error("histogram bin wrapped");
    low_flag_a: assert property (
        (go && temp_code <= s.thr_lo) |=> s.under_temp_flag)
        else $error("low flag not set");
    irq_gate_a: assert property (
        !irq_n |-> ((s.over_temp_flag && s.ctrl[`THAL_CTRL_OVER_TEMP_IRQ_EN]) ||
                    (s.under_temp_flag && s.ctrl[`THAL_CTRL_UNDER_TEMP_IRQ_EN]) ||
                    (s.time_match_flag && s.ctrl[`THAL_CTRL_AIE])))
        else $error("interrupt without enabled flag");
    stop_write_a: assert property (
        (wr && s.logging_active && s.ap_idx <= `THAL_IDX_CTRL &&
         s.ap_idx != `THAL_IDX_RATE) |=> !s.logging_active)
        else $error("mission survived register write");
    stamp_open_a: assert property (
        (go && temp_code >= s.thr_hi && !s.band[1].active &&
         s.band[1].idx < `THAL_ENTRIES)
        |=> s.band[1].idx == $past(s.band[1].idx) + 4'h1 &&
            s.log[12 + $past(s.band[1].idx)][23:0] == s.cnt)
        else $error("high stamp not opened");
    pulse_len_a: assert property (
        $rose(out_band_led_n)
        |-> s.led_busy && s.led_cyc == PULSE_CYC + 24'h000001)
        else $error("led pulse length wrong");
    bcd_zero_a: assert property (
        s.tod[3][7:3] == 5'h00 && s.tod[0][7] == 1'b0)
        else $error("fixed zero bit set");
    resv_bin_a: assert property (
        (n.ap_valid && !hwrite && ri >= 12'h87E && ri <= `THAL_IDX_HTOP)
        |=> hrdata == 32'h00000000)
        else $error("unused bin read non-zero");
    every_sec_a: assert property (
        (sec_tick && s.alm[0][7] && s.alm[1][7] && s.alm[2][7] &&
         s.alm[3][7]) |=> s.time_match_flag)
        else $error("per-second alarm missed");
    dur_wrap_a: assert property (
        (go && temp_code <= s.thr_lo && s.band[0].active &&
         s.band[0].dur == `THAL_DUR_MAX && s.band[0].idx < `THAL_ENTRIES)
        |=> s.band[0].dur == 8'h01)
        else $error("duration did not reopen");

    start_c: cover property ($rose(s.logging_active));
    alt_c:   cover property (status_req && s.logging_active && !s.first_seen);
    full_c:  cover property (s.band[0].idx == `THAL_ENTRIES);
    irq_c:   cover property ($fell(irq_n));
endmodule

//--- rtl/thal_pkg.sv
package thal_pkg;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        THAL_LED_BOTH,
        THAL_LED_IN,
        THAL_LED_OUT,
        THAL_LED_ALT
    } thal_led_mode_t;

    typedef struct packed {
        logic       active;
        logic [7:0] dur;
        logic [3:0] idx;
    } thal_band_t;

    typedef struct packed {
        logic [3:0][7:0]   tod;
        logic [3:0][7:0]   alm;
        logic [7:0]        thr_lo;
        logic [7:0]        thr_hi;
        logic [7:0]        rate;
        logic [7:0]        ctrl;
        logic              logging_active;
        logic              under_temp_flag;
        logic              over_temp_flag;
        logic              time_match_flag;
        logic [23:0]       cnt;
        logic [62:0][15:0] hist;
        logic [23:0][31:0] log;
        thal_band_t [1:0]  band;
        logic              viol_seen;
        logic              first_seen;
        logic              led_busy;
        thal_led_mode_t    led_mode;
        logic [1:0]        led_num;
        logic [23:0]       led_cyc;
        logic              led_in_n;
        logic              led_out_n;
        logic              btn_s1;
        logic              btn_s2;
        logic [23:0]       btn_cyc;
        logic              btn_done;
        logic              ap_valid;
        logic              ap_wr;
        logic [11:0]       ap_idx;
        logic [31:0]       hrdata;
        logic              irq_n;
        logic              hour_pm;
    } thal_state_t;
endpackage

//--- testbench/thal_logger_tb.sv
`include "thal_consts.svh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
end
module thal_logger_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 16;
    logic clk, reset, hsel, hwrite, sec_tick, sample_valid, spec_test_req;
    logic [31:0] haddr, hwdata, hrdata, hr_q, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  temp_code;
    logic        hreadyout, hresp, press, start_button_n;
    logic        in_band_led_n, out_band_led_n, irq_n, hour_pm;
    int n_fail, compares, cyc, p, k, s_i, s_o, s_b;
    int n_in, n_out, n_both, n_bad, cnt, under_temp_flag, over_temp_flag;
    int hist[64];
    int lg[96];
    int act[2], dur[2], ne[2];
    // ==========================================
    // Design and far side
    thal_logger #(.PULSE_CYC(24'd4), .PERIOD_CYC(24'd16), .HOLD_CYC(24'd8))
    DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sec_tick(sec_tick), .sample_valid(sample_valid),
        .temp_code(temp_code), .spec_test_req(spec_test_req),
        .start_button_n(start_button_n), .in_band_led_n(in_band_led_n),
        .out_band_led_n(out_band_led_n), .irq_n(irq_n), .hour_pm(hour_pm));
    thal_panel #(.PULSE(4), .PER(PER)) panel (.clk(clk), .reset(reset),
        .press(press), .in_band_led_n(in_band_led_n),
        .out_band_led_n(out_band_led_n), .start_button_n(start_button_n),
        .n_in(n_in), .n_out(n_out), .n_both(n_both), .n_bad(n_bad));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) hr_q <= hrdata;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ==========================================
    // Bus, checks and stimulus
    task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
        @(posedge clk);
        haddr <= {18'h0, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        #1 rdv = hr_q;
    endtask
    task automatic chk(input logic [11:0] i, input logic [7:0] e, string nm);
        bus(1'b0, i, 8'h00);
        `CHK(nm, {24'h0, e}, rdv)
    endtask
    task automatic leds(input int ei, input int eo, input int eb);
        repeat (5 * PER + 4) @(posedge clk);
        `CHK("leds", {ei, eo, eb}, {n_in - s_i, n_out - s_o, n_both - s_b})
        {s_i, s_o, s_b} = {n_in, n_out, n_both};
    endtask
    task automatic req();
        @(posedge clk) spec_test_req <= 1'b1;
        @(posedge clk) spec_test_req <= 1'b0;
    endtask
    task automatic smp(input int t);
        cnt++;
        if (t < 252) hist[t / 4]++;
        for (int b = 0; b < 2; b++) begin
            if (b ? t >= 'hB0 : t <= 'h40) begin
                if (b) over_temp_flag = 1;
                else under_temp_flag = 1;
                if (act[b] && dur[b] < 255) dur[b]++;
                else if (ne[b] < 12) begin
                    for (int j = 0; j < 3; j++) lg[b * 48 + ne[b] * 4 + j] = cnt >> (8 * j);
                    {dur[b], act[b]} = {32'd1, 32'd1};
                    ne[b]++;
                end else act[b] = 0;
                if (act[b]) lg[b * 48 + ne[b] * 4 - 1] = dur[b];
            end else act[b] = 0;
        end
        @(posedge clk);
        sample_valid <= 1'b1;
        temp_code <= 8'(t);
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {hsel, hwrite, sec_tick, sample_valid, spec_test_req, press} = '0;
        {haddr, hwdata, htrans, temp_code} = '0;
        hsize = 3'b010;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        hsel <= 1'b1;
        void'($urandom(48));
        bus(1'b1, 12'h100, 8'hFF);
        chk(12'h100, 8'h00, "unmapped");
        bus(1'b1, `THAL_IDX_SEC, 8'hFF);
        chk(`THAL_IDX_SEC, `THAL_MASK_TIME, "sec");
        bus(1'b1, `THAL_IDX_ADAY, 8'hFF);
        chk(`THAL_IDX_ADAY, `THAL_MASK_ADAY, "aday");
        bus(1'b1, `THAL_IDX_HOUR, 8'h72);
        `CHK("pm", 1'b1, hour_pm)
        bus(1'b1, `THAL_IDX_HOUR, 8'h23);
        `CHK("pm24", 1'b0, hour_pm)
        bus(1'b1, `THAL_IDX_SEC, 8'h10);
        bus(1'b1, `THAL_IDX_MIN, 8'h20);
        bus(1'b1, `THAL_IDX_DAY, 8'h02);
        bus(1'b1, `THAL_IDX_CTRL, 8'h01);
        for (p = 0; p < 5; p++) begin
            bus(1'b1, `THAL_IDX_ASEC, {p == 4, 7'h10});
            bus(1'b1, `THAL_IDX_AMIN, {p >= 3, 7'h20});
            bus(1'b1, `THAL_IDX_AHOUR, {p >= 2, 7'h05});
            bus(1'b1, `THAL_IDX_ADAY, {p >= 1, 7'h04});
            bus(1'b1, `THAL_IDX_STAT, 8'h00);
            @(posedge clk) sec_tick <= 1'b1;
            @(posedge clk) sec_tick <= 1'b0;
            chk(`THAL_IDX_STAT, {7'h0, p >= 2}, "alarm");
            `CHK("irq_alarm", !(p >= 2), irq_n)
        end
        bus(1'b1, `THAL_IDX_CTRL, 8'h06);
        `CHK("irq_off", 1'b1, irq_n)
        bus(1'b1, `THAL_IDX_STAT, 8'h00);
        bus(1'b1, `THAL_IDX_THR_LO, 8'h40);
        bus(1'b1, `THAL_IDX_THR_HI, 8'hB0);
        bus(1'b1, `THAL_IDX_RATE, 8'h01);
        chk(`THAL_IDX_STAT, 8'h20, "start");
        `CHK("hresp", 1'b0, hresp)
        leds(4, 4, 4);
        req();
        leds(2, 2, 0);
        smp('h40);
        repeat (257) smp($urandom_range(64));
        smp('hB0);
        repeat (80) smp($urandom_range(255));
        chk(`THAL_IDX_STAT, {5'h04, 1'(under_temp_flag), 1'(over_temp_flag), 1'b0}, "flags");
        `CHK("irq_t", !(under_temp_flag || over_temp_flag), irq_n)
        for (k = 0; k < 3; k++) chk(`THAL_IDX_CNT0 + k, 8'(cnt >> 8 * k), "cnt");
        for (k = 0; k < 128; k++) chk(`THAL_IDX_HIST + k, 8'(hist[k / 2] >> 8 * (k % 2)), "hist");
        for (k = 0; k < 96; k++) chk(`THAL_IDX_LOG_LO + k, 8'(lg[k]), "log");
        press <= 1'b1;
        repeat (12) @(posedge clk);
        press <= 1'b0;
        leds(0, 4, 0);
        bus(1'b1, `THAL_IDX_STAT, 8'h20);
        chk(`THAL_IDX_STAT, 8'h20, "clear");
        `CHK("irq_clr", 1'b1, irq_n)
        bus(1'b1, `THAL_IDX_THR_LO, 8'h40);
        chk(`THAL_IDX_STAT, 8'h00, "stop");
        smp('h80);
        chk(`THAL_IDX_CNT0, 8'(cnt - 1), "halted");
        bus(1'b1, `THAL_IDX_RATE, 8'h01);
        leds(4, 4, 4);
        smp('h80);
        req();
        leds(4, 0, 0);
        `CHK("pulse_shape", 0, n_bad)
        end_of_test();
    end
endmodule

//--- testbench/thal_panel.sv
module thal_panel #(
    parameter int PULSE = 4,
    parameter int PER   = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pins
    input  wire logic press,
    input  wire logic in_band_led_n,
    input  wire logic out_band_led_n,
    output logic      start_button_n,
    // Tallies
    output int        n_in,
    output int        n_out,
    output int        n_both,
    output int        n_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic p_in;
    logic p_out;
    logic fi;
    logic fo;
    int   w_in;
    int   w_out;
    int   gap;
    // ==========================================
    // Button with pull-up when released
    assign start_button_n = press ? 1'b0 : 1'b1;
    // ==========================================
    // Pulse width and spacing watch
    always @(posedge clk) begin
        if (reset) begin
            p_in = 1'b1;
            p_out = 1'b1;
            {n_in, n_out, n_both, n_bad, w_in, w_out} = '0;
            gap = 2 * PER;
        end else begin
            gap++;
            fi = p_in && !in_band_led_n;
            fo = p_out && !out_band_led_n;
            n_in += int'(fi);
            n_out += int'(fo);
            n_both += int'(fi && fo);
            if ((fi || fo) && gap < 2 * PER && gap != PER) n_bad++;
            if (fi || fo) gap = 0;
            if (!in_band_led_n) w_in++;
            else begin
                if (!p_in && w_in != PULSE) n_bad++;
                w_in = 0;
            end
            if (!out_band_led_n) w_out++;
            else begin
                if (!p_out && w_out != PULSE) n_bad++;
                w_out = 0;
            end
            p_in = in_band_led_n;
            p_out = out_band_led_n;
        end
    end
endmodule
